// ==== dbgevt_consts.svh ====
`ifndef DBGEVT_CONSTS_SVH
`define DBGEVT_CONSTS_SVH
`define DBGEVT_EIC_W 2
`define DBGEVT_EIC_BREAK 2'h1
`define DBGEVT_EOS_W 2
`define DBGEVT_EOS_ENTRY 2'h1
`define DBGEVT_EOS_HITS 2'h2
`define DBGEVT_NUNITS 4
`define DBGEVT_CTRL_RST 4'h0
`define DBGEVT_PIN_IDLE 1'h1
`endif

// ==== dbgevt_pkg.sv ====
`include "dbgevt_consts.svh"
package dbgevt_pkg;
  typedef struct packed {
    logic [`DBGEVT_EIC_W-1:0] event_in_ctrl;
    logic [`DBGEVT_EOS_W-1:0] event_out_select;
  } dbgevt_ctrl_t;
  typedef struct packed {
    logic [`DBGEVT_NUNITS-1:0] hit;
    logic [`DBGEVT_NUNITS-1:0] eoc;
  } dbgevt_units_t;
endpackage

// ==== dbgevt_pins.sv ====
`timescale 1ns/1ns
// Operation
// - event-in control 01: falling edge on event input raises breakpoint
// - external breakpoint sets the external breakpoint status flag
// - event-out select 01: event output low one cycle per debug entry
// - units with event-output bit set show hit status on event output
// - hit status shown on event output only when select is binary 10
`include "dbgevt_consts.svh"
module dbgevt_pins
  import dbgevt_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire dbgevt_ctrl_t debug_control_reg,
  input wire dbgevt_units_t units,
  input wire logic debug_entry,
  input wire logic ext_break_flag_clr,
  input wire logic event_in_pin,
  output logic event_out_pin,
  output logic ext_break_req,
  output logic ext_break_flag
);

  ////////////////////////////////////////////////////////////////////////////
  // input side: sampled pin history and the qualified falling edge
  logic event_in_q;
  logic fall;
  logic brk_arm;

  // output side: entry history and per-unit hit gating
  logic debug_entry_q;
  logic entry_rise;
  logic [`DBGEVT_NUNITS-1:0] unit_shown;
  logic any_hit;
  logic next_event_out;

  assign fall = event_in_q & ~event_in_pin;

  // only the break setting of the event-in control turns an edge into a break
  assign brk_arm = fall &&
    (debug_control_reg.event_in_ctrl == `DBGEVT_EIC_BREAK);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      event_in_q <= `DBGEVT_PIN_IDLE;
    end else begin
      event_in_q <= event_in_pin;
    end
  end

  // one-cycle breakpoint request toward the cpu
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ext_break_req <= 1'h0;
    end else begin
      ext_break_req <= fall &&
        (debug_control_reg.event_in_ctrl == `DBGEVT_EIC_BREAK);
    end
  end

  // set beats a simultaneous clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ext_break_flag <= 1'h0;
    end else if (fall &&
        debug_control_reg.event_in_ctrl == `DBGEVT_EIC_BREAK) begin
      ext_break_flag <= 1'h1;
    end else if (ext_break_flag_clr) begin
      ext_break_flag <= 1'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // debug_entry is a level; only its rise marks entry, so a cpu that stays
  // in debug mode still gives exactly one low cycle on the pin
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      debug_entry_q <= 1'h0;
    end else begin
      debug_entry_q <= debug_entry;
    end
  end

  assign entry_rise = debug_entry & ~debug_entry_q;

  // per-unit gate: a unit reaches the pin only with its enable bit set
  for (genvar n = 0; n < `DBGEVT_NUNITS; n++) begin : gen_unit
    assign unit_shown[n] = units.hit[n] & units.eoc[n];
  end

  assign any_hit = |unit_shown;

  // pin is active low: low means event
  always_comb begin
    case (debug_control_reg.event_out_select)
      `DBGEVT_EOS_ENTRY: next_event_out = ~entry_rise;
      `DBGEVT_EOS_HITS: next_event_out = ~any_hit;
      default: next_event_out = `DBGEVT_PIN_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      event_out_pin <= `DBGEVT_PIN_IDLE;
    end else begin
      event_out_pin <= next_event_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks on the input side
  brk_on_fall_a: assert property (@(posedge clk) disable iff (!nrst)
    $fell(event_in_pin) && debug_control_reg.event_in_ctrl == `DBGEVT_EIC_BREAK
    |=> ext_break_req && ext_break_flag)
    else $error("falling event input did not raise breakpoint");

  no_brk_other_a: assert property (@(posedge clk) disable iff (!nrst)
    debug_control_reg.event_in_ctrl != `DBGEVT_EIC_BREAK |=> !ext_break_req)
    else $error("breakpoint raised while event input disabled");

  req_pulse_a: assert property (@(posedge clk) disable iff (!nrst)
    ext_break_req
    |=> !ext_break_req)
    else $error("breakpoint request longer than one cycle");

  req_needs_fall_a: assert property (@(posedge clk) disable iff (!nrst)
    !brk_arm
    |=> !ext_break_req)
    else $error("breakpoint request without a falling edge");

  req_pin_low_a: assert property (@(posedge clk) disable iff (!nrst)
    ext_break_req
    |-> !event_in_q)
    else $error("breakpoint request while event input high");

  ////////////////////////////////////////////////////////////////////////////
  // checks on the sticky status flag
  flag_sticky_a: assert property (@(posedge clk) disable iff (!nrst)
    ext_break_flag && !ext_break_flag_clr |=> ext_break_flag)
    else $error("external break flag lost");

  flag_clear_a: assert property (@(posedge clk) disable iff (!nrst)
    ext_break_flag_clr && !$fell(event_in_pin) |=> !ext_break_flag)
    else $error("external break flag not cleared");

  flag_set_wins_a: assert property (@(posedge clk) disable iff (!nrst)
    brk_arm && ext_break_flag_clr
    |=> ext_break_flag)
    else $error("clear beat a simultaneous external break");

  flag_quiet_a: assert property (@(posedge clk) disable iff (!nrst)
    !ext_break_flag && !brk_arm
    |=> !ext_break_flag)
    else $error("external break flag set without an event");

  req_flag_a: assert property (@(posedge clk) disable iff (!nrst)
    ext_break_req
    |-> ext_break_flag)
    else $error("breakpoint request without status flag");

  ////////////////////////////////////////////////////////////////////////////
  // checks on the event output
  entry_pulse_a: assert property (@(posedge clk) disable iff (!nrst)
    debug_entry && !$past(debug_entry) &&
    debug_control_reg.event_out_select == `DBGEVT_EOS_ENTRY
    ##1 debug_control_reg.event_out_select == `DBGEVT_EOS_ENTRY
    && !debug_entry |-> !event_out_pin ##1 event_out_pin)
    else $error("debug entry pulse wrong");

  entry_once_a: assert property (@(posedge clk) disable iff (!nrst)
    entry_rise &&
    debug_control_reg.event_out_select == `DBGEVT_EOS_ENTRY
    ##1 debug_control_reg.event_out_select == `DBGEVT_EOS_ENTRY
    |-> !event_out_pin ##1 event_out_pin)
    else $error("debug entry low not exactly one cycle");

  entry_level_a: assert property (@(posedge clk) disable iff (!nrst)
    debug_control_reg.event_out_select == `DBGEVT_EOS_ENTRY &&
    debug_entry && debug_entry_q
    |=> event_out_pin)
    else $error("event output low while staying in debug mode");

  entry_idle_a: assert property (@(posedge clk) disable iff (!nrst)
    debug_control_reg.event_out_select == `DBGEVT_EOS_ENTRY &&
    !entry_rise
    |=> event_out_pin)
    else $error("event output low without debug entry");

  hit_show_a: assert property (@(posedge clk) disable iff (!nrst)
    debug_control_reg.event_out_select == `DBGEVT_EOS_HITS &&
    |(units.hit & units.eoc) |=> !event_out_pin)
    else $error("hit not shown on event output");

  hit_gate_a: assert property (@(posedge clk) disable iff (!nrst)
    debug_control_reg.event_out_select != `DBGEVT_EOS_HITS &&
    debug_control_reg.event_out_select != `DBGEVT_EOS_ENTRY
    |=> event_out_pin)
    else $error("event output active while disabled");

  masked_hit_a: assert property (@(posedge clk) disable iff (!nrst)
    debug_control_reg.event_out_select == `DBGEVT_EOS_HITS &&
    (units.hit & units.eoc) == '0 |=> event_out_pin)
    else $error("unselected unit shown on event output");

  ////////////////////////////////////////////////////////////////////////////
  // main scenarios
  brk_c: cover property (@(posedge clk) disable iff (!nrst) ext_break_req);

  entry_c: cover property (@(posedge clk) disable iff (!nrst)
    debug_control_reg.event_out_select == `DBGEVT_EOS_ENTRY && !event_out_pin);

  hit_c: cover property (@(posedge clk) disable iff (!nrst)
    debug_control_reg.event_out_select == `DBGEVT_EOS_HITS && !event_out_pin);

  set_wins_c: cover property (@(posedge clk) disable iff (!nrst)
    brk_arm && ext_break_flag_clr);

  entry_held_c: cover property (@(posedge clk) disable iff (!nrst)
    debug_control_reg.event_out_select == `DBGEVT_EOS_ENTRY &&
    debug_entry && debug_entry_q);

endmodule

// ==== dbgevt_trig.sv ====
`timescale 1ns/1ns
module dbgevt_trig (
  input wire logic clk,
  input wire logic go,
  output logic event_in_pin
);
  logic [1:0] cnt = 2'h0;
  initial event_in_pin = 1'h1;
  // falling edge, then low for two clocks before release
  always @(posedge clk) begin
    if (go) cnt <= 2'h2;
    else if (cnt != 2'h0) cnt <= cnt - 2'h1;
    event_in_pin <= !(go || cnt > 2'h1);
  end
endmodule

// ==== dbgevt_pins_tb_top.sv ====
`timescale 1ns/1ns
`include "dbgevt_consts.svh"
module dbgevt_pins_tb_top
  import dbgevt_pkg::*;
;
  logic clk = 0, nrst = 0, go = 0, entry = 0, clr = 0, eo, req, flag, evin;
  dbgevt_ctrl_t ctrl = '0;
  dbgevt_units_t u = '0;
  int err_count = 0, n_tests = 0;
  always #25 clk = ~clk;
  dbgevt_pins dbgevt_pins_inst (.clk(clk), .nrst(nrst),
    .debug_control_reg(ctrl), .units(u), .debug_entry(entry),
    .ext_break_flag_clr(clr), .event_in_pin(evin), .event_out_pin(eo),
    .ext_break_req(req), .ext_break_flag(flag));
  dbgevt_trig dbgevt_trig_inst (.clk(clk), .go(go), .event_in_pin(evin));
  task chk(string s, logic e, logic g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s exp %b got %b", s, e, g);
    end
  endtask
  function logic exp_eo(dbgevt_ctrl_t c, dbgevt_units_t v);
    return !(c.event_out_select == `DBGEVT_EOS_HITS && |(v.hit & v.eoc));
  endfunction
  task finish_test;
    $display("errors %0d checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    err_count++;
    finish_test;
  end
  initial begin
    void'($urandom(32'haf28));
    repeat (12) @(posedge clk);
    nrst <= 1;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      ctrl.event_in_ctrl <= i[1:0];
      go <= 1;
      clr <= 0;
      @(posedge clk) go <= 0;
      @(posedge clk) #1 chk("req", i == 1, req);
      chk("flag", i == 1, flag);
      @(posedge clk) #1 chk("req_end", 0, req);
      chk("flag_hold", i == 1, flag);
      @(posedge clk) clr <= 1;
    end
    @(posedge clk);
    ctrl.event_in_ctrl <= `DBGEVT_EIC_BREAK;
    go <= 1;
    @(posedge clk) go <= 0;
    @(posedge clk) #1 chk("flag_set_wins", 1, flag);
    @(posedge clk) #1 chk("flag_cleared", 0, flag);
    @(posedge clk) clr <= 0;
    @(posedge clk);
    ctrl.event_out_select <= `DBGEVT_EOS_ENTRY;
    entry <= 1;
    @(posedge clk) entry <= 0;
    #1 chk("entry_low", 0, eo);
    @(posedge clk) #1 chk("entry_end", 1, eo);
    @(posedge clk) entry <= 1;
    @(posedge clk) #1 chk("entry_held_low", 0, eo);
    @(posedge clk) #1 chk("entry_held", 1, eo);
    @(posedge clk) entry <= 0;
    for (int k = 0; k < 24; k++) begin
      @(posedge clk);
      ctrl <= k < 4 ? {2'h0, k[1:0]} : 4'($urandom);
      u <= k < 4 ? 8'h11 : 8'($urandom);
      @(posedge clk) #1 chk("evt_out", exp_eo(ctrl, u), eo);
    end
    finish_test;
  end
endmodule
